// >>> hw/sodl_pkg.sv
// package of constants and types for the safety output and diagnostic logic
package sodl_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_TICK_CYC = CLK_HZ / 1000;
    localparam int BLINK_HZ = 5;
    localparam int BLINK_HALF_MS = 1000 / (2 * BLINK_HZ);
    localparam int DISCREP_MS = 500;
    localparam int WARN_TRIP_MIN = 30;
    localparam int WARN_TRIP_MS = WARN_TRIP_MIN * 60 * 1000;
    localparam int MS_CNT_W = 16;
    localparam int LONG_CNT_W = 21;
    // ------------------------------------------------------------
    // bit positions
    // ------------------------------------------------------------
    localparam int RSP_OUT_EN = 0;
    localparam int RSP_ACT_DET = 1;
    localparam int RSP_FB_OPEN = 3;
    localparam int RSP_INPUTS = 4;
    localparam int RSP_LIMIT = 5;
    localparam int RSP_WARN = 6;
    localparam int RSP_ERR = 7;
    localparam int REQ_ACK = 6;
    localparam int REQ_RESET = 7;
    localparam int ERR_ACTUATOR = 4;
    localparam int ERR_INTERNAL = 5;
    localparam int ERR_DISCREP = 6;
    localparam int WRN_COMM = 6;
    localparam logic [7:0] DIAG_MASK = 8'h2F;
    typedef enum logic [1:0] {SODL_WAIT, SODL_ARMED, SODL_ON} sodl_state_t;
endpackage

// >>> hw/sodl_tick_if.sv
// interface carrying the millisecond tick between the modules
interface sodl_tick_if;
    logic ms_tick;
    logic blink;
    modport src (output ms_tick, output blink);
    modport dst (input ms_tick, input blink);
endinterface

// >>> hw/sodl_tick.sv
// millisecond tick and 5 Hz blink generator
module sodl_tick
    import sodl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    sodl_tick_if.src tk
);
    logic [15:0] div_r;
    logic [7:0] half_r;
    logic tick_r;
    logic blink_r;
    wire div_end = (div_r == 16'(MS_TICK_CYC - 1));
    wire half_end = (half_r == 8'(BLINK_HALF_MS - 1));
    // ------------------------------------------------------------
    // divider: one tick per millisecond
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            div_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_end ? 16'h0000 : div_r + 16'h0001;
            tick_r <= div_end;
        end
    end
    // blink toggles every 100 ms, giving 5 Hz
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            half_r <= 8'h00;
            blink_r <= 1'b0;
        end else if (tick_r) begin
            half_r <= half_end ? 8'h00 : half_r + 8'h01;
            if (half_end) blink_r <= ~blink_r;
        end
    end
    assign tk.ms_tick = tick_r;
    assign tk.blink = blink_r;
endmodule

// >>> hw/sodl_core.sv
// safety output release, discrepancy monitor and serial diagnostic bytes
module sodl_core
    import sodl_pkg::*;
#(
    parameter int WARN_TRIP_MS_P = WARN_TRIP_MS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic safety_input_a,
    input wire logic safety_input_b,
    input wire logic feedback_closed,
    input wire logic reset_button,
    input wire logic ack_button,
    input wire logic actuator_present,
    input wire logic actuator_limit,
    input wire logic actuator_bad,
    input wire logic internal_fault,
    input wire logic [5:0] warn_causes,
    input wire logic comm_error,
    input wire logic auto_release_variant,
    input wire logic edge_reset_variant,
    input wire logic discrep_enable,
    input wire logic [7:0] request_byte,
    input wire logic request_valid,
    input wire logic nv_fault_in,
    output logic nv_fault_wr,
    output logic nv_fault_data,
    output logic safety_output_a,
    output logic safety_output_b,
    output logic ready_led,
    output logic [7:0] response_byte,
    output logic [7:0] warning_flags,
    output logic [7:0] error_flags
);
    sodl_tick_if tk ();
    sodl_tick u_tick (.clk_sys(clk_sys), .rst_n(rst_n), .tk(tk));

    // ------------------------------------------------------------
    // pin synchronisers: two flops before any logic, except request_byte and request_valid
    // ------------------------------------------------------------
    localparam int NS = 13;
    logic [NS-1:0] s1_r, s2_r;
    wire [NS-1:0] pins = {nv_fault_in, discrep_enable, edge_reset_variant,
        auto_release_variant, internal_fault, actuator_bad, actuator_limit,
        actuator_present, ack_button, reset_button, feedback_closed,
        safety_input_b, safety_input_a};
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
        end
    end
    logic [5:0] w1_r, w2_r;
    logic c1_r, c2_r;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            w1_r <= 6'h00;
            w2_r <= 6'h00;
            c1_r <= 1'b0;
            c2_r <= 1'b0;
        end else begin
            w1_r <= warn_causes;
            w2_r <= w1_r;
            c1_r <= comm_error;
            c2_r <= c1_r;
        end
    end
    wire in_a = s2_r[0];
    wire in_b = s2_r[1];
    wire fb_closed = s2_r[2];
    wire rst_btn = s2_r[3];
    wire ack_btn = s2_r[4];
    wire act_det = s2_r[5];
    wire act_lim = s2_r[6];
    wire act_bad = s2_r[7];
    wire int_flt = s2_r[8];
    wire v_auto = s2_r[9];
    wire v_edge = s2_r[10];
    wire disc_on = s2_r[11];
    wire nv_in = s2_r[12];

    // edge history for buttons and the request reset bit
    logic rst_btn_d_r, ack_btn_d_r, req7_r, nv_loaded_r;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rst_btn_d_r <= 1'b0;
            ack_btn_d_r <= 1'b0;
            req7_r <= 1'b0;
        end else begin
            rst_btn_d_r <= rst_btn;
            ack_btn_d_r <= ack_btn;
            if (request_valid) req7_r <= request_byte[REQ_RESET];
        end
    end
    wire rst_fall = rst_btn_d_r & ~rst_btn;
    // only bits 6 and 7 of the request carry meaning; others ignored
    wire serial_ack = request_valid & request_byte[REQ_ACK];
    wire req7_fall = request_valid & req7_r & ~request_byte[REQ_RESET];
    wire ack_any = (ack_btn_d_r & ~ack_btn) | serial_ack;

    // ------------------------------------------------------------
    // discrepancy monitor
    // ------------------------------------------------------------
    logic [MS_CNT_W-1:0] disc_cnt_r;
    logic disc_flt_r;
    wire inputs_differ = in_a ^ in_b;
    wire disc_trip = disc_on & inputs_differ
        & (disc_cnt_r >= MS_CNT_W'(DISCREP_MS));
    // timer runs from first input off until the second follows; it stops at the
    // limit so it cannot wrap and re-arm while monitoring is switched off
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            disc_cnt_r <= '0;
        end else if (!inputs_differ) begin
            disc_cnt_r <= '0;
        end else if (tk.ms_tick && (disc_cnt_r < MS_CNT_W'(DISCREP_MS))) begin
            disc_cnt_r <= disc_cnt_r + MS_CNT_W'(1);
        end
    end
    // the fault reloads from the non-volatile copy after reset, but only once the
    // synchroniser holds the real cell value: before that it still reads zero
    localparam logic [1:0] NV_LOAD_AT = 2'h2;
    logic [1:0] ld_cnt_r;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            disc_flt_r <= 1'b0;
            nv_loaded_r <= 1'b0;
            ld_cnt_r <= 2'h0;
        end else begin
            if (ld_cnt_r != NV_LOAD_AT) ld_cnt_r <= ld_cnt_r + 2'h1;
            else nv_loaded_r <= 1'b1;
            if (!nv_loaded_r) disc_flt_r <= nv_in;
            else if (disc_trip) disc_flt_r <= 1'b1;                         // set wins
            else if (ack_any) disc_flt_r <= 1'b0;
        end
    end
    // store writes happen on every change of the latched fault once the cell value is loaded
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            nv_fault_wr <= 1'b0;
            nv_fault_data <= 1'b0;
        end else begin
            nv_fault_wr <= nv_loaded_r & (disc_flt_r != nv_fault_data);
            nv_fault_data <= nv_loaded_r ? disc_flt_r : nv_in;
        end
    end

    // ------------------------------------------------------------
    // internal fault latch and warning timer
    // ------------------------------------------------------------
    logic int_flt_r;
    wire guard_open = ~act_det;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            int_flt_r <= 1'b0;
        end else if (int_flt) begin
            int_flt_r <= 1'b1;
        end else if (req7_fall || guard_open) begin
            int_flt_r <= 1'b0;
        end
    end
    logic [LONG_CNT_W-1:0] warn_ms_r;
    logic warn_trip_r;
    // only defined causes count; comm errors keep the outputs as they are
    wire warn_any = |({2'b00, w2_r} & DIAG_MASK);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            warn_ms_r <= '0;
            warn_trip_r <= 1'b0;
        end else if (!warn_any) begin
            warn_ms_r <= '0;
            warn_trip_r <= 1'b0;
        end else if (tk.ms_tick) begin
            if (warn_ms_r >= LONG_CNT_W'(WARN_TRIP_MS_P - 1)) warn_trip_r <= 1'b1;
            else warn_ms_r <= warn_ms_r + LONG_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // release state machine
    // ------------------------------------------------------------
    sodl_state_t st_r, st_nxt;
    wire hard_off = disc_flt_r | disc_trip | int_flt_r | warn_trip_r | act_bad;
    // edge variant wins when both straps are set: the safer reading
    wire release_ok = v_edge ? rst_fall : v_auto;
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            SODL_WAIT: if (fb_closed && !hard_off && nv_loaded_r) st_nxt = SODL_ARMED;
            SODL_ARMED: begin
                if (!fb_closed || hard_off) st_nxt = SODL_WAIT;
                else if (release_ok && in_a && in_b) st_nxt = SODL_ON;
            end
            // comm errors are not a cause here: outputs hold their state
            SODL_ON: if (hard_off || !(in_a & in_b)) st_nxt = SODL_WAIT;
            default: st_nxt = SODL_WAIT;
        endcase
    end
    wire out_on = (st_nxt == SODL_ON);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= SODL_WAIT;
            safety_output_a <= 1'b0;
            safety_output_b <= 1'b0;
            ready_led <= 1'b0;
        end else begin
            st_r <= st_nxt;
            safety_output_a <= out_on;
            safety_output_b <= out_on;
            ready_led <= out_on | ((st_nxt != SODL_ON) & tk.blink);
        end
    end

    // ------------------------------------------------------------
    // diagnostic bytes, undefined bits forced low
    // ------------------------------------------------------------
    wire [7:0] err_nxt = {1'b0, disc_flt_r | disc_trip, int_flt_r, act_bad, 4'h0};
    wire [7:0] warn_nxt = ({2'b00, w2_r} & DIAG_MASK) | (8'(c2_r) << WRN_COMM);
    wire [7:0] rsp_nxt = {|err_nxt, |warn_nxt, act_lim, in_a & in_b,
        ~fb_closed, 1'b0, act_det, out_on};
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            response_byte <= 8'h00;
            warning_flags <= 8'h00;
            error_flags <= 8'h00;
        end else begin
            response_byte <= rsp_nxt;
            warning_flags <= warn_nxt;
            error_flags <= err_nxt;
        end
    end
endmodule

// >>> tb/sodl_gateway_model.sv
// behavioural model of the gateway that writes request bytes
module sodl_gateway_model (
    input wire logic clk_sys,
    output logic [7:0] request_byte,
    output logic request_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // bus idles low before the first request
    initial begin
        request_byte = 8'h00;
        request_valid = 1'b0;
    end
    // one-cycle request, then a gap so back-to-back calls never collide
    task automatic send(input logic [7:0] b);
        request_byte <= b;
        request_valid <= 1'b1;
        @(posedge clk_sys);
        request_valid <= 1'b0;
        request_byte <= ~b; // idle bus shows junk, never the last value
        @(posedge clk_sys);
    endtask
endmodule

// >>> tb/sodl_core_properties.sv
// concurrent checks on the ports of the safety output and diagnostic logic
module sodl_core_properties
    import sodl_pkg::*;
#(
    parameter int WARN_TRIP_MS_P = WARN_TRIP_MS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic safety_input_a,
    input wire logic actuator_limit,
    input wire logic actuator_bad,
    input wire logic comm_error,
    input wire logic safety_output_a,
    input wire logic safety_output_b,
    input wire logic ready_led,
    input wire logic [7:0] response_byte,
    input wire logic [7:0] warning_flags,
    input wire logic [7:0] error_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // both channels always switch together
    AST_OUT_PAIR: assert property (safety_output_a == safety_output_b)
        else $error("safety outputs disagree");
    AST_EN_BIT: assert property (safety_output_a |-> ##[0:1] response_byte[RSP_OUT_EN])
        else $error("enable bit missing");
    AST_INPUT_BIT: assert property ((!safety_input_a) [*5] |-> !response_byte[RSP_INPUTS])
        else $error("inputs bit set with input off");
    AST_INPUT_OFF: assert property ((!safety_input_a) [*6] |-> !safety_output_a)
        else $error("output on with input off");
    AST_LIMIT: assert property (actuator_limit [*5] |-> response_byte[RSP_LIMIT])
        else $error("limit bit missing");
    AST_BAD: assert property (actuator_bad [*5] |-> error_flags[ERR_ACTUATOR])
        else $error("actuator error bit missing");
    // a latched discrepancy blocks release until acknowledged
    AST_DISC_LOCK: assert property (error_flags[ERR_DISCREP] && $past(error_flags[ERR_DISCREP])
        |-> !safety_output_a)
        else $error("output released over discrepancy");
    AST_RSV_ZERO: assert property (!response_byte[2] && !warning_flags[4] && !warning_flags[7]
        && ((error_flags & 8'h8F) == 8'h00))
        else $error("undefined status bit set");
    AST_COMM: assert property (comm_error [*5] |-> warning_flags[WRN_COMM])
        else $error("comm warning missing");
    AST_LED: assert property (safety_output_a && $past(safety_output_a) |-> ready_led)
        else $error("led not steady while enabled");
endmodule
bind sodl_core sodl_core_properties #(.WARN_TRIP_MS_P(WARN_TRIP_MS_P)) u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .safety_input_a(safety_input_a),
    .actuator_limit(actuator_limit), .actuator_bad(actuator_bad), .comm_error(comm_error),
    .safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
    .ready_led(ready_led), .response_byte(response_byte), .warning_flags(warning_flags),
    .error_flags(error_flags)
);

// >>> tb/sodl_core_tb.sv
// self-checking testbench for the safety output and diagnostic logic
module sodl_core_tb import sodl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst_n = 1'b0, in_a = 1'b0, in_b = 1'b0, fb = 1'b0, rst_btn = 1'b0;
    logic ack_btn = 1'b0, present = 1'b0, limit = 1'b0, bad = 1'b0, int_f = 1'b0;
    logic comm = 1'b0, auto_v = 1'b1, edge_v = 1'b0, nv_in = 1'b0, nv_wr, nv_data;
    logic [5:0] warn = 6'h00;
    logic [7:0] req, rsp, wrn, err;
    logic req_v, out_a, out_b, led;
    int err_count = 0, checked = 0, n;
    // clock and gateway model
    always #10 clk_sys = ~clk_sys;
    sodl_gateway_model gw (.clk_sys(clk_sys), .request_byte(req), .request_valid(req_v));
    sodl_core #(.WARN_TRIP_MS_P(2)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .safety_input_a(in_a), .safety_input_b(in_b),
        .feedback_closed(fb), .reset_button(rst_btn), .ack_button(ack_btn),
        .actuator_present(present), .actuator_limit(limit), .actuator_bad(bad),
        .internal_fault(int_f), .warn_causes(warn), .comm_error(comm),
        .auto_release_variant(auto_v), .edge_reset_variant(edge_v), .discrep_enable(1'b1),
        .request_byte(req), .request_valid(req_v), .nv_fault_in(nv_in),
        .nv_fault_wr(nv_wr), .nv_fault_data(nv_data), .safety_output_a(out_a),
        .safety_output_b(out_b), .ready_led(led), .response_byte(rsp),
        .warning_flags(wrn), .error_flags(err));
    // non-volatile cell keeps whatever the design last wrote
    always @(posedge clk_sys) if (nv_wr === 1'b1) nv_in <= nv_data;
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // callers wait for the falling edge, where outputs are settled
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
        @(posedge clk_sys);
    endtask
    task automatic wrap_up();
        if (err_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // reset with fault loaded from the cell, then let it settle
    task automatic reboot(input logic f);
        rst_n <= 1'b0;
        nv_in <= f;
        cyc(3);
        rst_n <= 1'b1;
        cyc(8);
    endtask
    initial begin
        cyc(12);
        rst_n <= 1'b1;
        cyc(4);
        @(negedge clk_sys) chk({6'h00, out_a, rsp[RSP_OUT_EN]}, 8'h00);
        in_a <= 1'b1;
        in_b <= 1'b1;
        present <= 1'b1;
        cyc(8);
        @(negedge clk_sys) chk(rsp, 8'h1A);
        fb <= 1'b1;
        cyc(8);
        @(negedge clk_sys) chk(rsp, 8'h13);
        limit <= 1'b1;
        cyc(8);
        @(negedge clk_sys) chk(rsp, 8'h33);
        limit <= 1'b0;
        comm <= 1'b1;
        cyc(8);
        @(negedge clk_sys) chk({wrn[7:1], out_b}, 8'h41);
        comm <= 1'b0;
        // cause bit 4 is undefined and must not show in the warning byte
        warn <= 6'h11;
        n = 0;
        while (out_a === 1'b1 && n < 110000) begin
            @(posedge clk_sys);
            n++;
        end
        @(negedge clk_sys) chk({7'h00, n >= 50000 && n <= 100010}, 8'h01);
        @(negedge clk_sys) chk(wrn, 8'h01);
        warn <= 6'h00;
        cyc(8);
        @(negedge clk_sys) chk({7'h00, out_a}, 8'h01);
        bad <= 1'b1;
        cyc(8);
        @(negedge clk_sys) chk(err, 8'h10);
        bad <= 1'b0;
        int_f <= 1'b1;
        cyc(8);
        int_f <= 1'b0;
        cyc(8);
        gw.send(8'h3F);
        @(negedge clk_sys) chk(err, 8'h20);
        gw.send(8'h80);
        gw.send(8'h00);
        cyc(3);
        @(negedge clk_sys) chk(err, 8'h00);
        edge_v <= 1'b1;
        in_a <= 1'b0;
        cyc(8);
        in_a <= 1'b1;
        cyc(8);
        @(negedge clk_sys) chk({7'h00, out_a}, 8'h00);
        rst_btn <= 1'b1;
        cyc(4);
        rst_btn <= 1'b0;
        cyc(8);
        @(negedge clk_sys) chk({6'h00, out_a, out_b}, 8'h03);
        reboot(1'b1);
        @(negedge clk_sys) chk({err[7:1], out_a}, 8'h40);
        ack_btn <= 1'b1;
        cyc(4);
        ack_btn <= 1'b0;
        cyc(8);
        @(negedge clk_sys) chk({err[7:1], nv_in}, 8'h00);
        reboot(1'b1);
        gw.send(8'h40);
        cyc(3);
        @(negedge clk_sys) chk(err, 8'h00);
        // with neither strap set nothing releases; the auto strap alone then does
        edge_v <= 1'b0;
        auto_v <= 1'b0;
        cyc(8);
        @(negedge clk_sys) chk({7'h00, out_a}, 8'h00);
        auto_v <= 1'b1;
        cyc(8);
        @(negedge clk_sys) chk({7'h00, out_a}, 8'h01);
        wrap_up();
    end
    // watchdog: the warning wait takes at most about 100k cycles, the rest a few hundred
    initial begin
        #2_400_000;
        err_count++;
        wrap_up();
    end
endmodule
